// ==== dv/etio_ext_eq.sv ====
`timescale 1ns/100ps
module etio_ext_eq (
    input  wire logic        i_clk,
    input  wire logic        i_lvl_req,
    input  wire logic [15:0] i_min_hold,
    input  wire logic        i_dev_oe,
    input  wire logic        i_dev_out,
    output logic             o_pin
);
    logic        lvl_reg = 1'b0;
    logic [15:0] age_reg = 16'h0000;

    // level moves only after the previous one has stood long enough
    always_ff @(posedge i_clk) begin
        if (i_lvl_req != lvl_reg && age_reg >= i_min_hold) begin
            lvl_reg <= i_lvl_req;
            age_reg <= 16'h0000;
        end else if (age_reg != 16'hFFFF) begin
            age_reg <= age_reg + 16'h0001;
        end
    end

    // shared connector: the device wins while it drives
    assign o_pin = i_dev_oe ? i_dev_out : lvl_reg;
endmodule // etio_ext_eq

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cyc_end = 1'b0;
    logic        lvl = 1'b0;
    logic [15:0] hold = 16'h0004;
    logic [3:0]  ce_ph = 4'h0;
    logic [31:0] rdata, d;
    logic        pin, pin_out, pin_oe, start, busy, run, hold_ph, hop;
    int          error_cnt = 0, n_compared = 0, cyc_cnt = 0;
    int          n_start = 0, n_hi = 0, n_ce_busy = 0, n0, h0, c0, n, p;

    etio_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_trig_pin_in(pin),
        .o_trig_pin_out(pin_out), .o_trig_pin_oe(pin_oe), .i_cycle_end(cyc_end),
        .o_start(start), .o_burst_busy(busy), .o_run(run), .o_hold_phase(hold_ph),
        .o_hop(hop));
    etio_ext_eq ext_eq (.i_clk(clk), .i_lvl_req(lvl), .i_min_hold(hold),
        .i_dev_oe(pin_oe), .i_dev_out(pin_out), .o_pin(pin));

    // clock
    always #4 clk = ~clk;

    // waveform cycle ends every 16 cycles, event counters and hang guard
    always @(posedge clk) begin
        ce_ph   <= ce_ph + 4'h1;
        cyc_end <= (ce_ph == 4'hF);
        if (start === 1'b1) n_start++;
        if (pin_out === 1'b1) n_hi++;
        if (cyc_end === 1'b1 && busy === 1'b1) n_ce_busy++;
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic set_lvl(input logic v, input int k);
        @(posedge clk);
        lvl <= v;
        cyc(k);
    endtask

    // control word from mode, source and flag settings
    function automatic logic [31:0] ctrl_w(input logic [1:0] m, input logic [1:0] s,
        input logic sl, input logic oe, input logic fa, input logic nz, input logic ky);
        ctrl_w = 32'h0000_0000;
        ctrl_w[etio_pkg::CTRL_MODE_LSB +: 2] = m;
        ctrl_w[etio_pkg::CTRL_SRC_LSB +: 2]  = s;
        ctrl_w[etio_pkg::CTRL_SLOPE]    = sl;
        ctrl_w[etio_pkg::CTRL_OUT_EN]   = oe;
        ctrl_w[etio_pkg::CTRL_OUT_FALL] = fa;
        ctrl_w[etio_pkg::CTRL_NOISE]    = nz;
        ctrl_w[etio_pkg::CTRL_KEY_EXT]  = ky;
    endfunction

    // main sequence
    initial begin
        void'($urandom(32'h7bd0185a));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        bus_rd(etio_pkg::OFS_CTRL, d);
        chk("ctrl_rst", 32'(etio_pkg::CTRL_RST), d);
        bus_rd(etio_pkg::OFS_PERIOD, d);
        chk("period_rst", etio_pkg::PERIOD_RST, d);
        bus_rd(etio_pkg::OFS_COUNT, d);
        chk("count_rst", 32'(etio_pkg::COUNT_RST), d);
        bus_rd(8'h20, d);
        chk("unmapped", 32'h0000_0000, d);
        // external sweep, both slopes, one start per matching edge
        for (int s = 0; s < 2; s++) begin
            bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_SWEEP, etio_pkg::ETIO_SRC_EXT,
                s[0], 1'b1, 1'b0, 1'b0, 1'b0));
            cyc(3);
            chk("oe_ext", 32'h0000_0000, 32'(pin_oe));
            for (int k = 0; k < 4; k++) begin
                n0 = n_start;
                set_lvl(~lvl, 10);
                chk("sweep_starts", 32'(lvl ^ s[0]), n_start - n0);
            end
        end
        // external burst with retrigger while busy
        n = 3 + ($urandom % 4);
        bus_wr(etio_pkg::OFS_COUNT, n);
        bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_BURST, etio_pkg::ETIO_SRC_EXT,
            1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        n0 = n_start;
        c0 = n_ce_busy;
        set_lvl(1'b1, 8);
        chk("burst_busy", 32'h0000_0001, 32'(busy));
        set_lvl(1'b0, 4);
        set_lvl(1'b1, 8);
        chk("burst_retrig", 32'h0000_0001, n_start - n0);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) cyc(1);
        cyc(2);
        chk("burst_cycles", n, n_ce_busy - c0);
        // keyed FSK, levels held at the fastest legal toggle rate
        bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_FSK, etio_pkg::ETIO_SRC_IMM,
            1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        hold <= 16'h0271;
        for (int k = 0; k < 6; k++) begin
            set_lvl(1'($urandom % 2), 630);
            chk("hop", 32'(lvl), 32'(hop));
        end
        hold <= 16'h0004;
        // gated burst, normal then noise
        set_lvl(1'b0, 8);
        for (int nz = 0; nz < 2; nz++) begin
            bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_GATED, etio_pkg::ETIO_SRC_IMM,
                1'b0, 1'b0, 1'b0, nz[0], 1'b0));
            set_lvl(1'b1, 40);
            chk("run_gate", 32'h0000_0001, 32'(run));
            bus_rd(etio_pkg::OFS_STATUS, d);
            chk("status_run", 32'h0000_000A, d);
            while (ce_ph != 4'h2) cyc(1);
            set_lvl(1'b0, 8);
            chk("run_drain", 32'(!nz[0]), 32'(run));
            cyc(12);
            chk("run_stop", 32'h0000_0000, 32'(run));
            chk("hold_phase", 32'h0000_0001, 32'(hold_ph));
        end
        // immediate then timer source square marker, both polarities
        p = 2 * (5 + ($urandom % 16));
        bus_wr(etio_pkg::OFS_PERIOD, p);
        for (int f = 0; f < 2; f++) begin
            bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_SWEEP,
                f[0] ? etio_pkg::ETIO_SRC_TIMER : etio_pkg::ETIO_SRC_IMM,
                1'b0, 1'b1, f[0], 1'b0, 1'b0));
            cyc(3);
            chk("oe_on", 32'h0000_0001, 32'(pin_oe));
            for (int i = 0; i < 300 && start !== 1'b1; i++) cyc(1);
            cyc(2);
            chk("mark_edge", 32'(!f[0]), 32'(pin_out));
            h0 = n_hi;
            n0 = n_start;
            cyc(4 * p);
            chk("square_hi", 2 * p, n_hi - h0);
            chk("imm_starts", 32'h0000_0004, n_start - n0);
        end
        // bus trigger gives one wide pulse
        bus_wr(etio_pkg::OFS_CTRL, ctrl_w(etio_pkg::ETIO_SWEEP, etio_pkg::ETIO_SRC_BUS,
            1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        cyc(200);
        h0 = n_hi;
        n0 = n_start;
        bus_wr(etio_pkg::OFS_TRIG, $urandom);
        cyc(300);
        chk("bus_starts", 32'h0000_0001, n_start - n0);
        chk("pulse_wide", 32'h0000_0001,
            32'((n_hi - h0) * etio_pkg::CLK_NS > 1000 && n_hi - h0 < 300));
        // reset in mid-run restores defaults
        @(posedge clk);
        rst_b <= 1'b0;
        cyc(4);
        @(posedge clk);
        rst_b <= 1'b1;
        bus_rd(etio_pkg::OFS_CTRL, d);
        chk("ctrl_rst2", 32'(etio_pkg::CTRL_RST), d);
        chk("oe_rst2", 32'h0000_0000, 32'(pin_oe));
        final_report();
    end
endmodule // tb_top

// ==== hdl/etio_marker.sv ====
`timescale 1ns/100ps
module etio_marker (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    etio_mk_if.gen    mk
);
    localparam int PW = etio_pkg::PULSE_CYC;

    logic [31:0] cnt_reg;
    logic        mark_reg;
    logic [31:0] half;

    assign half    = mk.period >> 1;
    assign mk.mark = mark_reg;

    // square wave high for half the period, pulse high for the fixed width
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_reg  <= 32'h0000_0000;
            mark_reg <= 1'b0;
        end else if (mk.start && (mk.sq_mode || mk.pulse_mode)) begin
            cnt_reg  <= 32'h0000_0000;
            mark_reg <= 1'b1;
        end else if (mark_reg) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            if (!mk.sq_mode && !mk.pulse_mode) begin
                mark_reg <= 1'b0;                               // source went external
            end else if (mk.sq_mode && (cnt_reg + 32'h0000_0001 >= half)) begin
                mark_reg <= 1'b0;
            end else if (mk.pulse_mode && (cnt_reg >= 32'(PW - 1))) begin
                mark_reg <= 1'b0;
            end
        end
    end

    mark_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (mk.start && (mk.sq_mode || mk.pulse_mode)) |=> mark_reg)
        else $error("marker did not rise at start");
    pulse_width_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (mark_reg && mk.pulse_mode && !mk.sq_mode) |-> (cnt_reg < 32'(PW)))
        else $error("bus pulse longer than its width");
    square_half_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (mark_reg && mk.sq_mode && !mk.start && (cnt_reg + 32'h0000_0001 >= half))
        |=> !mark_reg)
        else $error("square wave not low after half period");
    pulse_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        mk.pulse_mode && $fell(mark_reg));
endmodule // etio_marker

// ==== hdl/etio_mk_if.sv ====
`timescale 1ns/100ps
// marker request from control logic to marker generator
interface etio_mk_if;
    logic        start;
    logic        sq_mode;
    logic        pulse_mode;
    logic [31:0] period;
    logic        mark;

    modport drv (output start, output sq_mode, output pulse_mode, output period, input mark);
    modport gen (input start, input sq_mode, input pulse_mode, input period, output mark);
endinterface

// ==== hdl/etio_pkg.sv ====
package etio_pkg;
    // clock and marker pulse timing
    localparam int CLK_NS    = 8;
    localparam int PULSE_NS  = 1000;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS + 1; // strictly wider

    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_COUNT  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_TRIG   = 8'h10;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_LSB  = 2;
    localparam int CTRL_SLOPE    = 4;
    localparam int CTRL_OUT_EN   = 5;
    localparam int CTRL_OUT_FALL = 6;
    localparam int CTRL_NOISE    = 7;
    localparam int CTRL_KEY_EXT  = 8;
    localparam int CTRL_WIDTH    = 9;

    // reset values
    localparam logic [8:0]  CTRL_RST   = 9'h000;
    localparam logic [31:0] PERIOD_RST = 32'h0000_1000;
    localparam logic [15:0] COUNT_RST  = 16'h0001;

    typedef enum logic [1:0] {
        ETIO_SWEEP = 2'b00,
        ETIO_BURST = 2'b01,
        ETIO_FSK   = 2'b10,
        ETIO_GATED = 2'b11
    } etio_mode_t;

    typedef enum logic [1:0] {
        ETIO_SRC_IMM   = 2'b00,
        ETIO_SRC_EXT   = 2'b01,
        ETIO_SRC_BUS   = 2'b10,
        ETIO_SRC_TIMER = 2'b11
    } etio_src_t;

    typedef enum logic [1:0] {
        ETIO_G_IDLE  = 2'b00,
        ETIO_G_RUN   = 2'b01,
        ETIO_G_DRAIN = 2'b11
    } etio_gate_t;
endpackage

// ==== hdl/etio_top.sv ====
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
module etio_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_trig_pin_in,
    output logic             o_trig_pin_out,
    output logic             o_trig_pin_oe,
    input  wire logic        i_cycle_end,
    output logic             o_start,
    output logic             o_burst_busy,
    output logic             o_run,
    output logic             o_hold_phase,
    output logic             o_hop
);
    // address match used by reads and writes
    function automatic logic f_hit(input logic [7:0] a, input logic [7:0] ofs);
        f_hit = (a == ofs);
    endfunction

    logic [etio_pkg::CTRL_WIDTH-1:0] ctrl_reg;
    logic [31:0]                     period_reg;
    logic [15:0]                     count_reg;
    logic [31:0]                     rdata_reg;
    logic                            pin_meta_reg;
    logic                            pin_sync_reg;
    logic                            pin_prev_reg;
    logic [31:0]                     tmr_reg;
    logic [15:0]                     cyc_reg;
    logic                            busy_reg;
    logic                            start_reg;
    logic                            hop_reg;
    etio_pkg::etio_gate_t            gate_reg;
    etio_pkg::etio_mode_t            mode;
    etio_pkg::etio_src_t             src;
    logic                            slope_fall;
    logic                            out_en;
    logic                            out_fall;
    logic                            noise;
    logic                            key_ext;
    logic                            trig_mode;
    logic                            edge_hit;
    logic                            gate_true;
    logic                            int_src;
    logic                            tmr_tick;
    logic                            ext_start;
    logic                            bus_start;
    logic                            start_req;
    logic                            out_active;

    etio_mk_if mk ();

    // control field decode
    assign mode       = etio_pkg::etio_mode_t'(ctrl_reg[etio_pkg::CTRL_MODE_LSB +: 2]);
    assign src        = etio_pkg::etio_src_t'(ctrl_reg[etio_pkg::CTRL_SRC_LSB +: 2]);
    assign slope_fall = ctrl_reg[etio_pkg::CTRL_SLOPE];
    assign out_en     = ctrl_reg[etio_pkg::CTRL_OUT_EN];
    assign out_fall   = ctrl_reg[etio_pkg::CTRL_OUT_FALL];
    assign noise      = ctrl_reg[etio_pkg::CTRL_NOISE];
    assign key_ext    = ctrl_reg[etio_pkg::CTRL_KEY_EXT];
    assign trig_mode  = (mode == etio_pkg::ETIO_SWEEP) || (mode == etio_pkg::ETIO_BURST);
    assign int_src    = (src == etio_pkg::ETIO_SRC_IMM) || (src == etio_pkg::ETIO_SRC_TIMER);

    // register writes
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_reg   <= etio_pkg::CTRL_RST;
            period_reg <= etio_pkg::PERIOD_RST;
            count_reg  <= etio_pkg::COUNT_RST;
        end else if (i_wr) begin
            if (f_hit(i_addr, etio_pkg::OFS_CTRL)) begin
                ctrl_reg <= i_wdata[etio_pkg::CTRL_WIDTH-1:0];
            end
            if (f_hit(i_addr, etio_pkg::OFS_PERIOD)) begin
                period_reg <= i_wdata;
            end
            if (f_hit(i_addr, etio_pkg::OFS_COUNT)) begin
                count_reg <= i_wdata[15:0];
            end
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_rd) begin
            if (f_hit(i_addr, etio_pkg::OFS_CTRL)) begin
                rdata_reg <= {{(32 - etio_pkg::CTRL_WIDTH){1'b0}}, ctrl_reg};
            end else if (f_hit(i_addr, etio_pkg::OFS_PERIOD)) begin
                rdata_reg <= period_reg;
            end else if (f_hit(i_addr, etio_pkg::OFS_COUNT)) begin
                rdata_reg <= {16'h0000, count_reg};
            end else if (f_hit(i_addr, etio_pkg::OFS_STATUS)) begin
                rdata_reg <= {26'h000_0000, o_trig_pin_out, hop_reg, o_run, busy_reg,
                              pin_sync_reg, o_trig_pin_oe};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end
    assign o_rdata = rdata_reg;

    // two-stage pin synchroniser and edge history
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= i_trig_pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // selected slope and gate polarity
    assign edge_hit  = slope_fall ? (pin_prev_reg && !pin_sync_reg)
                                  : (!pin_prev_reg && pin_sync_reg);
    assign gate_true = pin_sync_reg ^ slope_fall;

    // trigger sources; a running burst masks every new start
    assign ext_start = trig_mode && (src == etio_pkg::ETIO_SRC_EXT) && edge_hit
                       && !busy_reg;
    assign bus_start = trig_mode && (src == etio_pkg::ETIO_SRC_BUS) && i_wr
                       && f_hit(i_addr, etio_pkg::OFS_TRIG) && !busy_reg;
    assign tmr_tick  = trig_mode && int_src && (tmr_reg + 32'h0000_0001 >= period_reg);
    assign start_req = ext_start || bus_start || (tmr_tick && !busy_reg);

    // period timer for immediate and timer sources
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tmr_reg <= 32'h0000_0000;
        end else if (!trig_mode || !int_src || tmr_tick) begin
            tmr_reg <= 32'h0000_0000;
        end else begin
            tmr_reg <= tmr_reg + 32'h0000_0001;
        end
    end

    // start pulse to the sweep and burst engines
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_req;
        end
    end
    assign o_start = start_reg;

    // burst busy: counts completed cycles up to the programmed count
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            busy_reg <= 1'b0;
            cyc_reg  <= 16'h0000;
        end else if (mode != etio_pkg::ETIO_BURST) begin
            busy_reg <= 1'b0;
            cyc_reg  <= 16'h0000;
        end else if (start_req) begin
            busy_reg <= 1'b1;
            cyc_reg  <= 16'h0000;
        end else if (busy_reg && i_cycle_end) begin
            cyc_reg <= cyc_reg + 16'h0001;
            if (cyc_reg + 16'h0001 >= count_reg) begin
                busy_reg <= 1'b0;
            end
        end
    end
    assign o_burst_busy = busy_reg;

    // gated burst: run while gate true, drain to cycle end, noise stops at once
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            gate_reg <= etio_pkg::ETIO_G_IDLE;
        end else if (mode != etio_pkg::ETIO_GATED) begin
            gate_reg <= etio_pkg::ETIO_G_IDLE;
        end else begin
            unique case (gate_reg)
                etio_pkg::ETIO_G_IDLE: begin
                    if (gate_true) begin
                        gate_reg <= etio_pkg::ETIO_G_RUN;
                    end
                end
                etio_pkg::ETIO_G_RUN: begin
                    if (!gate_true) begin
                        gate_reg <= noise ? etio_pkg::ETIO_G_IDLE
                                          : etio_pkg::ETIO_G_DRAIN;
                    end
                end
                etio_pkg::ETIO_G_DRAIN: begin
                    if (gate_true) begin
                        gate_reg <= etio_pkg::ETIO_G_RUN;
                    end else if (i_cycle_end || noise) begin
                        gate_reg <= etio_pkg::ETIO_G_IDLE;
                    end
                end
                default: begin
                    gate_reg <= etio_pkg::ETIO_G_IDLE;
                end
            endcase
        end
    end
    assign o_run        = (gate_reg != etio_pkg::ETIO_G_IDLE);
    assign o_hold_phase = (mode == etio_pkg::ETIO_GATED) && (gate_reg == etio_pkg::ETIO_G_IDLE);

    // keyed FSK frequency select
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            hop_reg <= 1'b0;
        end else begin
            hop_reg <= (mode == etio_pkg::ETIO_FSK) && key_ext && pin_sync_reg;
        end
    end
    assign o_hop = hop_reg;

    // trigger output: pin driven only for internal, timer or bus sources
    assign out_active    = out_en && trig_mode && (src != etio_pkg::ETIO_SRC_EXT);
    assign mk.start      = start_req && out_active;
    assign mk.sq_mode    = int_src;
    assign mk.pulse_mode = (src == etio_pkg::ETIO_SRC_BUS);
    assign mk.period     = period_reg;

    etio_marker u_marker (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .mk      (mk)
    );

    // marker polarity and pin enable
    assign o_trig_pin_out = mk.mark ^ out_fall;
    assign o_trig_pin_oe  = out_active;

    ext_one_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ext_start |=> (o_start ##1 !o_start))
        else $error("external edge did not give exactly one start");
    sync_two_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(pin_sync_reg) |-> $past(pin_meta_reg))
        else $error("pin reached logic without two stages");
    burst_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (busy_reg && (mode == etio_pkg::ETIO_BURST)) |-> !start_req)
        else $error("start taken during a burst");
    fsk_hop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((mode == etio_pkg::ETIO_FSK) && key_ext) [*2] |-> (o_hop == $past(pin_sync_reg)))
        else $error("hop select does not follow the pin");
    gate_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((mode == etio_pkg::ETIO_GATED) && gate_true) ##1 (mode == etio_pkg::ETIO_GATED)
        |-> o_run)
        else $error("gate true but output not running");
    noise_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((mode == etio_pkg::ETIO_GATED) && noise && !gate_true && o_run) |=> !o_run)
        else $error("noise did not stop on gate false");
    drain_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((gate_reg == etio_pkg::ETIO_G_RUN) && !gate_true && !noise
         && (mode == etio_pkg::ETIO_GATED) && !i_cycle_end) |=> o_run)
        else $error("gated output stopped before cycle end");
    ext_no_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (src == etio_pkg::ETIO_SRC_EXT) |-> !o_trig_pin_oe)
        else $error("trigger output driven with external source");

    // checks on burst length, marker form, reset defaults and gate drain
    burst_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($fell(busy_reg) && ($past(mode) == etio_pkg::ETIO_BURST))
        |-> $past(i_cycle_end))
        else $error("burst ended without a cycle end");
    bus_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (mk.start && mk.pulse_mode && !mk.sq_mode)
        |=> ##125 mk.mark)
        else $error("bus marker pulse too narrow");
    rst_src_a: assert property (@(posedge i_clk)
        !i_rst_b
        |=> ((src == etio_pkg::ETIO_SRC_IMM) && !out_fall && !o_trig_pin_oe))
        else $error("reset did not restore immediate source");
    mark_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (start_req && out_active)
        |=> (o_start && mk.mark))
        else $error("marker not at sweep or burst start");
    oe_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !trig_mode |-> !o_trig_pin_oe)
        else $error("trigger output driven outside sweep or burst");
    drain_stay_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((gate_reg == etio_pkg::ETIO_G_DRAIN) && !gate_true && !i_cycle_end && !noise
         && (mode == etio_pkg::ETIO_GATED)) |=> o_run)
        else $error("drain stopped before cycle end");
    hold_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((gate_reg == etio_pkg::ETIO_G_DRAIN) && !gate_true && i_cycle_end
         && (mode == etio_pkg::ETIO_GATED)) |=> (o_hold_phase || (mode != etio_pkg::ETIO_GATED)))
        else $error("output not held at start phase after drain");

    // main scenarios reached
    timer_start_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        tmr_tick && (src == etio_pkg::ETIO_SRC_TIMER));
    burst_start_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        ext_start && (mode == etio_pkg::ETIO_BURST));
    gate_drain_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        (gate_reg == etio_pkg::ETIO_G_DRAIN) ##1 (gate_reg == etio_pkg::ETIO_G_IDLE));
    fsk_hop_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_hop));
endmodule // etio_top
